// [rtl/multiply_negate_move_exec.sv]
// Purpose: Executes store, multiply, negate and no-operation instructions
// Assumes: Data memory reads are synchronous with one cycle of latency
// Notes: One instruction cycle is four core_clk quarters
//
// What this block does
// RULE1: Store copies accumulator to the file register; accumulator and flags unchanged.
// RULE2: Access bit 0, extended set on, address up to 95 uses indexed offset.
// RULE3: One word, one instruction cycle: decode, read, process, write quarters.
// RULE4: Literal multiply forms unsigned accumulator times literal into the product pair.
// RULE5: File multiply puts accumulator times file into product; sources unchanged.
// RULE6: Both multiplies leave all status flags untouched.
// RULE7: Literal multiply leaves the accumulator unchanged.
// RULE8: Access bit 0 selects access bank; 1 uses bank select register.
// RULE9: Negate replaces the file register with its inverse plus one.
// RULE10: Negate updates negative, range, carry, nibble carry and zero flags.
// RULE11: All-zero word and top nibble 1111 are one-cycle no-operations.
// RULE12: Otherwise access bit 0 uses plain access bank addressing.
module multiply_negate_move_exec
  import mne_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic arst_n,
  // Instruction stream
  input logic instr_valid,
  input logic [INSTR_W-1:0] instr_word,
  output logic instr_taken,
  output logic instr_done,
  output logic [3:0] q_phase,
  // Data memory
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic [DATA_W-1:0] mem_wdata,
  input logic [DATA_W-1:0] mem_rdata,
  // Register port
  input logic [REG_ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  phase_t phase;
  phase_t next_phase;
  op_t cur_op;
  logic cur_valid;
  logic cur_nop;
  logic cur_a;
  logic cur_lit;
  logic [7:0] cur_f;
  logic [DATA_W-1:0] acc;
  logic [BANK_W-1:0] bank_select_register;
  logic [FLAG_W-1:0] status;
  logic [DATA_W-1:0] product_high;
  logic [DATA_W-1:0] product_low;
  logic ext_enable;
  logic [ADDR_W-1:0] index_base;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic is_store;
  logic is_neg;
  logic is_mul_file;
  logic is_mul_lit;
  logic is_nop;
  logic needs_file;
  op_t dec_op;
  logic [7:0] dec_f;
  logic dec_a;

  assign dec_f = instr_word[7:0];
  assign dec_a = instr_word[8];
  assign is_store = (instr_word[15:9] == OPC_STORE_ACC);  // [RULE1]
  assign is_neg = (instr_word[15:9] == OPC_NEGATE);  // [RULE9]
  assign is_mul_file = (instr_word[15:9] == OPC_MUL_FILE);  // [RULE5]
  assign is_mul_lit = (instr_word[15:8] == OPC_MUL_LIT);  // [RULE4]
  assign is_nop = (instr_word == NOP_ZERO_WORD) ||
                  (instr_word[15:12] == NOP_TOP_NIBBLE);  // [RULE11]
  assign needs_file = is_store || is_neg || is_mul_file;
  assign dec_op = is_store ? OP_STORE_ACC :
                  (is_mul_file || is_mul_lit) ? OP_MUL :
                  is_neg ? OP_NEG : OP_NONE;

  // ----------------------------------------------------------------------
  // Operand address resolution
  // ----------------------------------------------------------------------
  logic index_mode;
  logic [ADDR_W-1:0] index_addr;
  logic [ADDR_W-1:0] access_addr;
  logic [ADDR_W-1:0] bank_addr;
  logic [ADDR_W-1:0] next_addr;

  assign index_mode = !dec_a && ext_enable && (dec_f <= INDEX_LIMIT);  // [RULE2]
  assign index_addr = 12'(index_base + {4'h0, dec_f});  // [RULE2]
  assign access_addr = (dec_f <= INDEX_LIMIT) ? {ACCESS_LOW_BANK, dec_f} :
                       {ACCESS_HIGH_BANK, dec_f};  // [RULE12]
  assign bank_addr = {bank_select_register, dec_f};  // [RULE8]
  assign next_addr = dec_a ? bank_addr : index_mode ? index_addr : access_addr;  // [RULE8]

  // ----------------------------------------------------------------------
  // Quarter phase sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (phase)
      PH_DECODE: next_phase = PH_READ;  // [RULE3]
      PH_READ: next_phase = PH_PROC;
      PH_PROC: next_phase = PH_WRITE;
      PH_WRITE: next_phase = PH_DECODE;
      default: next_phase = PH_DECODE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PH_DECODE;
    end else begin
      phase <= next_phase;
    end
  end

  // Instruction capture in the decode quarter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_valid <= 1'b0;
      cur_op <= OP_NONE;
      cur_nop <= 1'b0;
      cur_a <= 1'b0;
      cur_lit <= 1'b0;
      cur_f <= 8'h00;
      mem_addr <= 12'h000;
      mem_rd_en <= 1'b0;
      instr_taken <= 1'b0;
    end else if (phase == PH_DECODE) begin
      cur_valid <= instr_valid;
      cur_op <= instr_valid ? dec_op : OP_NONE;
      cur_nop <= instr_valid && is_nop;
      cur_a <= dec_a;
      cur_lit <= is_mul_lit;
      cur_f <= dec_f;
      mem_addr <= next_addr;
      mem_rd_en <= instr_valid && needs_file;  // [RULE3]
      instr_taken <= instr_valid;
    end else begin
      mem_rd_en <= 1'b0;
      instr_taken <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------------
  math_if math ();
  logic [DATA_W-1:0] mul_operand;

  assign mul_operand = cur_lit ? cur_f : mem_rdata;  // [RULE4] [RULE5]
  assign math.acc = acc;
  assign math.operand = mul_operand;

  byte_math_unit u_math (
    .math(math.unit)
  );

  // ----------------------------------------------------------------------
  // Process quarter results, visible in the write quarter
  // ----------------------------------------------------------------------
  logic exec_proc;
  logic exec_store;
  logic exec_neg;
  logic exec_mul;

  assign exec_proc = (phase == PH_PROC) && cur_valid;
  assign exec_store = exec_proc && (cur_op == OP_STORE_ACC);
  assign exec_neg = exec_proc && (cur_op == OP_NEG);
  assign exec_mul = exec_proc && (cur_op == OP_MUL);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_wr_en <= 1'b0;
      mem_wdata <= 8'h00;
      instr_done <= 1'b0;
    end else begin
      mem_wr_en <= exec_store || exec_neg;  // [RULE1] [RULE9]
      if (exec_store) begin
        mem_wdata <= acc;  // [RULE1]
      end else if (exec_neg) begin
        mem_wdata <= math.neg_result;  // [RULE9]
      end
      instr_done <= exec_proc;
    end
  end

  // ----------------------------------------------------------------------
  // Architectural registers: execution wins over a same-cycle bus write
  // ----------------------------------------------------------------------
  logic wr_acc;
  logic wr_bank;
  logic wr_status;
  logic wr_prod_low;
  logic wr_prod_high;
  logic wr_ctrl;
  logic wr_index_low;
  logic wr_index_high;

  assign wr_acc = reg_wr && (reg_addr == REG_ACC);
  assign wr_bank = reg_wr && (reg_addr == REG_BANK);
  assign wr_status = reg_wr && (reg_addr == REG_STATUS);
  assign wr_prod_low = reg_wr && (reg_addr == REG_PROD_LOW);
  assign wr_prod_high = reg_wr && (reg_addr == REG_PROD_HIGH);
  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign wr_index_low = reg_wr && (reg_addr == REG_INDEX_LOW);
  assign wr_index_high = reg_wr && (reg_addr == REG_INDEX_HIGH);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= ACC_RST;
      bank_select_register <= BANK_RST;
      ext_enable <= CTRL_EXT_RST;
      index_base <= INDEX_RST;
    end else begin
      if (wr_acc) acc <= reg_wdata;  // [RULE7]
      if (wr_bank) bank_select_register <= reg_wdata[BANK_W-1:0];
      if (wr_ctrl) ext_enable <= reg_wdata[CTRL_EXT_BIT];
      if (wr_index_low) index_base[7:0] <= reg_wdata;
      if (wr_index_high) index_base[11:8] <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= STATUS_RST;
      product_low <= PROD_RST;
      product_high <= PROD_RST;
    end else begin
      if (exec_neg) begin
        status <= math.neg_flags;  // [RULE10] [RULE6]
      end else if (wr_status) begin
        status <= reg_wdata[FLAG_W-1:0];
      end
      if (exec_mul) begin
        product_high <= math.product[15:8];  // [RULE4]
        product_low <= math.product[7:0];
      end else begin
        if (wr_prod_low) product_low <= reg_wdata;
        if (wr_prod_high) product_high <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] read_mux;

  assign read_mux = (reg_addr == REG_ACC) ? acc :
                    (reg_addr == REG_BANK) ? {4'h0, bank_select_register} :
                    (reg_addr == REG_STATUS) ? {3'h0, status} :
                    (reg_addr == REG_PROD_LOW) ? product_low :
                    (reg_addr == REG_PROD_HIGH) ? product_high :
                    (reg_addr == REG_CTRL) ? {7'h00, ext_enable} :
                    (reg_addr == REG_INDEX_LOW) ? index_base[7:0] :
                    {4'h0, index_base[11:8]};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      q_phase <= PH_DECODE;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
      q_phase <= next_phase;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  store_copy_a: assert property (  // [RULE1]
    exec_store && !reg_wr |=> mem_wr_en && mem_wdata == $past(acc) && $stable(status)
  ) else $error("store did not copy accumulator");

  index_addr_a: assert property (  // [RULE2]
    phase == PH_READ && cur_valid && !cur_a && $past(ext_enable) && cur_f <= INDEX_LIMIT
    |-> mem_addr == 12'($past(index_base) + {4'h0, cur_f})
  ) else $error("indexed offset address wrong");

  phase_seq_a: assert property (  // [RULE3]
    phase == PH_DECODE && instr_valid |=> instr_taken && phase == PH_READ
    ##1 phase == PH_PROC ##1 instr_done && phase == PH_WRITE ##1 phase == PH_DECODE
  ) else $error("instruction cycle quarters out of order");

  mul_product_a: assert property (  // [RULE4]
    exec_mul && !reg_wr
    |=> {product_high, product_low} == {8'h00, $past(acc)} * {8'h00, $past(mul_operand)}
  ) else $error("product pair wrong");

  mul_file_a: assert property (  // [RULE5]
    exec_mul && !cur_lit && !reg_wr |=> !mem_wr_en && $stable(acc)
  ) else $error("file multiply changed a source");

  mul_flags_a: assert property (  // [RULE6]
    exec_mul && !reg_wr |=> $stable(status)
  ) else $error("multiply touched status");

  mul_lit_acc_a: assert property (  // [RULE7]
    exec_mul && cur_lit && !reg_wr |=> $stable(acc) [*2]
  ) else $error("literal multiply changed accumulator");

  bank_addr_a: assert property (  // [RULE8]
    phase == PH_READ && cur_valid && cur_a
    |-> mem_addr == {$past(bank_select_register), cur_f}
  ) else $error("bank select address wrong");

  negate_value_a: assert property (  // [RULE9]
    exec_neg |=> mem_wr_en && mem_wdata == 8'(~$past(mem_rdata) + 8'h01)
  ) else $error("negate result wrong");

  negate_flags_a: assert property (  // [RULE10]
    exec_neg |=> status[ZERO_FLAG] == (mem_wdata == 8'h00)
    && status[NEGATIVE_FLAG] == mem_wdata[7]
    && status[CARRY_FLAG] == ($past(mem_rdata) == 8'h00)
    && status[SIGNED_RANGE_FLAG] == ($past(mem_rdata) == 8'h80)
    && status[NIBBLE_CARRY_FLAG] == ($past(mem_rdata[3:0]) == 4'h0)
  ) else $error("negate flags wrong");

  nop_quiet_a: assert property (  // [RULE11]
    phase == PH_DECODE && instr_valid && is_nop && !reg_wr ##1 !reg_wr ##1 !reg_wr
    |=> !mem_wr_en && !$past(mem_rd_en, 2) && $stable(status)
    && $stable({product_high, product_low})
  ) else $error("no-operation changed state");

  access_plain_a: assert property (  // [RULE12]
    phase == PH_READ && cur_valid && !cur_a && !($past(ext_enable) && cur_f <= INDEX_LIMIT)
    |-> mem_addr == {(cur_f <= INDEX_LIMIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, cur_f}
  ) else $error("access bank address wrong");

  store_seen_c: cover property (exec_store ##1 mem_wr_en);
  mul_seen_c: cover property (exec_mul && cur_lit ##1 product_high != 8'h00);
  neg_seen_c: cover property (exec_neg ##1 status[ZERO_FLAG]);
  index_seen_c: cover property (phase == PH_DECODE && instr_valid && index_mode && needs_file);
  nop_seen_c: cover property (phase == PH_READ && cur_nop);

endmodule

// [rtl/mne_pkg.sv]
// Purpose: Shared constants and types for the byte instruction datapath
// Assumes: 8-bit data, 12-bit data memory address, 16-bit program words
// Notes: Register map offsets are word indices on the plain register port
package mne_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int FLAG_W = 5;
  localparam int INSTR_W = 16;
  localparam int REG_ADDR_W = 3;

  // ----------------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------------
  localparam logic [6:0] OPC_STORE_ACC = 7'h37;
  localparam logic [6:0] OPC_NEGATE = 7'h36;
  localparam logic [6:0] OPC_MUL_FILE = 7'h01;
  localparam logic [7:0] OPC_MUL_LIT = 8'h0d;
  localparam logic [15:0] NOP_ZERO_WORD = 16'h0000;
  localparam logic [3:0] NOP_TOP_NIBBLE = 4'hf;

  // ----------------------------------------------------------------------
  // Operand addressing
  // ----------------------------------------------------------------------
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_BANK = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_PROD_LOW = 3'h3;
  localparam logic [2:0] REG_PROD_HIGH = 3'h4;
  localparam logic [2:0] REG_CTRL = 3'h5;
  localparam logic [2:0] REG_INDEX_LOW = 3'h6;
  localparam logic [2:0] REG_INDEX_HIGH = 3'h7;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [7:0] PROD_RST = 8'h00;
  localparam logic CTRL_EXT_RST = 1'b0;
  localparam logic [11:0] INDEX_RST = 12'h000;

  // ----------------------------------------------------------------------
  // Status flag bit positions
  // ----------------------------------------------------------------------
  localparam int CARRY_FLAG = 0;
  localparam int NIBBLE_CARRY_FLAG = 1;
  localparam int ZERO_FLAG = 2;
  localparam int SIGNED_RANGE_FLAG = 3;
  localparam int NEGATIVE_FLAG = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_DECODE = 4'b0001,
    PH_READ = 4'b0010,
    PH_PROC = 4'b0100,
    PH_WRITE = 4'b1000
  } phase_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0001,
    OP_STORE_ACC = 4'b0010,
    OP_MUL = 4'b0100,
    OP_NEG = 4'b1000
  } op_t;

endpackage

// [rtl/math_if.sv]
// Purpose: Carries operands and results between core and arithmetic unit
// Assumes: Purely combinational unit on the far side
// Notes: None
interface math_if;
  import mne_pkg::*;

  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] operand;
  logic [2*DATA_W-1:0] product;
  logic [DATA_W-1:0] neg_result;
  logic [FLAG_W-1:0] neg_flags;

  modport unit (input acc, input operand, output product, output neg_result, output neg_flags);
  modport core (output acc, output operand, input product, input neg_result, input neg_flags);
endinterface

// [rtl/byte_math_unit.sv]
// Purpose: Unsigned 8x8 multiply and two's complement negate with flags
// Assumes: Operands are stable for the process quarter
// Notes: Combinational; the core registers every result
module byte_math_unit
  import mne_pkg::*;
(
  // Operand and result carrier
  math_if.unit math
);

  logic [DATA_W-1:0] neg_value;
  logic [FLAG_W-1:0] flags;

  // Product never overflows the 16-bit pair
  assign math.product = {8'h00, math.acc} * {8'h00, math.operand};
  assign neg_value = 8'(~math.operand + 8'h01);
  assign math.neg_result = neg_value;

  // Negate is 0 - f: carry means no borrow, only for f = 0
  assign flags[CARRY_FLAG] = (math.operand == 8'h00);
  assign flags[NIBBLE_CARRY_FLAG] = (math.operand[3:0] == 4'h0);
  assign flags[ZERO_FLAG] = (neg_value == 8'h00);
  assign flags[SIGNED_RANGE_FLAG] = (math.operand == 8'h80);
  assign flags[NEGATIVE_FLAG] = neg_value[7];
  assign math.neg_flags = flags;

endmodule

// [bench/multiply_negate_move_exec_test.sv]
// Purpose: Self-checking bench for the byte instruction datapath
// Assumes: Bench plays the data memory and the register port master
// Notes: Each word is offered during the decode quarter
module multiply_negate_move_exec_test
  import mne_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr_word = 16'h0000;
  logic [DATA_W-1:0] mem_rdata = 8'h00;
  logic [REG_ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic instr_taken, instr_done, mem_rd_en, mem_wr_en;
  logic [3:0] q_phase;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata, reg_rdata;
  logic [7:0] rv;
  int failures = 0;
  int tests_run = 0;

  multiply_negate_move_exec dut_u (
    .core_clk(core_clk), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_taken(instr_taken), .instr_done(instr_done), .q_phase(q_phase),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic expect_reg(input string what, input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    check(what, {8'h00, rv}, {8'h00, e});
  endtask

  // Read mode: 0 no read, 1 read at addr, 2 read not judged
  task automatic exec(input logic [15:0] w, input logic [7:0] rd, input int rd_mode,
                      input logic [11:0] addr, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge core_clk);
    while (q_phase !== 4'b1000 && n < 16) begin
      @(negedge core_clk);
      n++;
    end
    check("write quarter", q_phase, 4'b1000);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    instr_word <= ~w;
    #1;
    check("instr_taken", instr_taken, 1'b1);
    if (rd_mode != 2) check("mem_rd_en", mem_rd_en, rd_mode == 1);
    if (rd_mode == 1) check("read addr", mem_addr, addr);
    @(posedge core_clk);
    mem_rdata <= rd;
    #1;
    check("instr_done early", instr_done, 1'b0);
    @(posedge core_clk);
    mem_rdata <= ~rd;
    #1;
    check("instr_done", instr_done, 1'b1);
    check("mem_wr_en", mem_wr_en, wr);
    if (wr) begin
      check("write data", mem_wdata, wd);
      check("write addr", mem_addr, addr);
    end
  endtask

  function automatic logic [7:0] neg_flags(input logic [7:0] f);
    logic [7:0] r;
    r = ~f + 8'h01;
    neg_flags = 8'h00;
    neg_flags[NEGATIVE_FLAG] = r[7];
    neg_flags[ZERO_FLAG] = (r == 8'h00);
    neg_flags[CARRY_FLAG] = (f == 8'h00);
    neg_flags[NIBBLE_CARRY_FLAG] = (f[3:0] == 4'h0);
    neg_flags[SIGNED_RANGE_FLAG] = (f == 8'h80);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] ma[4] = '{8'he2, 8'hff, 8'h00, 8'h9b};
    logic [7:0] mk[4] = '{8'hc4, 8'hff, 8'h37, 8'h01};
    logic [7:0] nv[6] = '{8'h3a, 8'h00, 8'h80, 8'h10, 8'h01, 8'h7f};
    logic [15:0] p;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      expect_reg("reset value", i[2:0], 8'h00);
    end
    $display("reset value test done");

    reg_write(REG_ACC, 8'h4f);
    reg_write(REG_BANK, 8'h02);
    reg_write(REG_STATUS, 8'h15);
    exec(16'h6f10, 8'hff, 1, 12'h210, 1'b1, 8'h4f);
    exec(16'h6e20, 8'hff, 1, 12'h020, 1'b1, 8'h4f);
    exec(16'h6ea0, 8'hff, 1, 12'hfa0, 1'b1, 8'h4f);
    expect_reg("store acc", REG_ACC, 8'h4f);
    expect_reg("store status", REG_STATUS, 8'h15);
    $display("store test done");

    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        p = {8'h00, ma[i]} * {8'h00, mk[i]};
        reg_write(REG_ACC, ma[i]);
        if (j == 0) exec({OPC_MUL_LIT, mk[i]}, 8'h00, 0, 12'h000, 1'b0, 8'h00);
        else exec(16'h0310, mk[i], 1, 12'h210, 1'b0, 8'h00);
        expect_reg("product high", REG_PROD_HIGH, p[15:8]);
        expect_reg("product low", REG_PROD_LOW, p[7:0]);
        expect_reg("mul acc", REG_ACC, ma[i]);
        expect_reg("mul status", REG_STATUS, 8'h15);
      end
    end
    $display("multiply test done");

    for (int i = 0; i < 6; i++) begin
      exec(16'h6d10, nv[i], 1, 12'h210, 1'b1, ~nv[i] + 8'h01);
      expect_reg("negate flags", REG_STATUS, neg_flags(nv[i]));
    end
    $display("negate test done");

    reg_write(REG_CTRL, 8'h01);
    reg_write(REG_INDEX_LOW, 8'h34);
    reg_write(REG_INDEX_HIGH, 8'h01);
    exec(16'h6c05, 8'h3a, 1, 12'h139, 1'b1, 8'hc6);
    exec(16'h6c5f, 8'h3a, 1, 12'h193, 1'b1, 8'hc6);
    exec(16'h6c60, 8'h3a, 1, 12'hf60, 1'b1, 8'hc6);
    exec(16'h6d05, 8'h3a, 1, 12'h205, 1'b1, 8'hc6);
    reg_write(REG_INDEX_LOW, 8'hff);
    reg_write(REG_INDEX_HIGH, 8'h0f);
    reg_write(REG_ACC, 8'h01);
    exec(16'h0205, 8'h11, 1, 12'h004, 1'b0, 8'h00);
    expect_reg("indexed product", REG_PROD_LOW, 8'h11);
    reg_write(REG_CTRL, 8'h00);
    exec(16'h6c05, 8'h3a, 1, 12'h005, 1'b1, 8'hc6);
    $display("addressing test done");

    reg_write(REG_ACC, 8'h5c);
    reg_write(REG_STATUS, 8'h0a);
    exec(NOP_ZERO_WORD, 8'h00, 0, 12'h000, 1'b0, 8'h00);
    exec(16'hf123, 8'h00, 0, 12'h000, 1'b0, 8'h00);
    exec(16'hffff, 8'h00, 0, 12'h000, 1'b0, 8'h00);
    expect_reg("nop acc", REG_ACC, 8'h5c);
    expect_reg("nop status", REG_STATUS, 8'h0a);
    expect_reg("nop product high", REG_PROD_HIGH, 8'h00);
    expect_reg("nop product low", REG_PROD_LOW, 8'h11);
    $display("no-operation test done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("watchdog expired");
    test_done();
  end
endmodule
